// ---- rtl/fcs_pkg.sv ----
package fcs_pkg;
    // bus geometry of the flash part
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam int SECT_LSB = 16;

    // command data values
    localparam logic [7:0] CMD_UNLOCK1    = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2    = 8'h55;
    localparam logic [7:0] CMD_RESET      = 8'hf0;
    localparam logic [7:0] CMD_PROGRAM    = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SET  = 8'h80;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
    localparam logic [7:0] CMD_RESUME     = 8'h30;
    localparam logic [7:0] CMD_AUTOSEL    = 8'h90;
    localparam logic [7:0] CMD_BYPASS     = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT   = 8'h00;

    // autoselect low-address offsets
    localparam logic [7:0] AS_MAKER   = 8'h00;
    localparam logic [7:0] AS_PART    = 8'h01;
    localparam logic [7:0] AS_PROTECT = 8'h02;

    // register byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;

    // ctrl fields
    localparam int CTRL_GO_LSB = 0;   // write 1 starts operation
    localparam int CTRL_OP_LSB = 4;   // 4-bit operation code
    localparam int CTRL_ACC    = 8;   // accelerate pin level

    // status fields
    localparam int ST_BUSY    = 0;
    localparam int ST_READY   = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_POLL    = 3;
    localparam int ST_TOGGLE  = 4;

    // timing: strobe phase width in ns and cycles at 25 MHz
    localparam int CLK_NS    = 40;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_LAT_CYC = 2;  // extra read pulse cycles so synchronised data settles

    // host operations
    typedef enum logic [3:0] {
        FCS_OP_READ    = 4'h0,
        FCS_OP_RESET   = 4'h1,
        FCS_OP_PROGRAM = 4'h2,
        FCS_OP_CHIP_ER = 4'h3,
        FCS_OP_SECT_ER = 4'h4,
        FCS_OP_SUSPEND = 4'h5,
        FCS_OP_RESUME  = 4'h6,
        FCS_OP_AUTOSEL = 4'h7,
        FCS_OP_BYPASS  = 4'h8,
        FCS_OP_BYP_PGM = 4'h9,
        FCS_OP_BYP_EXT = 4'ha,
        FCS_OP_RAW     = 4'hb
    } fcs_op_e;

    // one bus cycle on the flash pins
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcs_cycle_s;

    // pin bundle toward flash
    typedef struct packed {
        logic              chip_select_n;
        logic              write_strobe_n;
        logic              output_enable_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_out;
        logic              data_oe;
    } fcs_pins_s;
endpackage

// ---- rtl/fcs_cycle.sv ----
`timescale 1ns/1ns
// runs one write or read cycle on the flash pins
module fcs_cycle (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       resetn,
    // request
    input  wire logic                       start,
    input  wire fcs_pkg::fcs_cycle_s        req,
    output logic                            done,
    output logic [fcs_pkg::DATA_W-1:0]      rdata,
    // pins
    output fcs_pkg::fcs_pins_s              pins,
    input  wire logic [fcs_pkg::DATA_W-1:0] data_sync
);
    import fcs_pkg::*;

    typedef enum logic [3:0] {
        FCS_C_IDLE  = 4'b0001,
        FCS_C_SETUP = 4'b0010,
        FCS_C_PULSE = 4'b0100,
        FCS_C_HOLD  = 4'b1000
    } fcs_cst_e;

    fcs_cst_e   state;
    logic [3:0] cnt;
    logic       wr;

    // strobe sequencing; address set while strobe high, data latched at its rise
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= FCS_C_IDLE;
            cnt   <= 4'h0;
            wr    <= 1'b0;
            done  <= 1'b0;
            rdata <= 8'h00;
            pins  <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_enable_n: 1'b1,
                       addr: '0, data_out: 8'h00, data_oe: 1'b0};
        end else begin
            done <= 1'b0;
            case (state)
                FCS_C_IDLE: begin
                    if (start) begin
                        wr            <= req.write;
                        pins.addr     <= req.addr;
                        pins.data_out <= req.data;
                        pins.data_oe  <= req.write;
                        pins.chip_select_n <= 1'b0;
                        // reads outlast the pin flop and both sync stages
                        cnt   <= req.write ? 4'(STROBE_CYC) : 4'(STROBE_CYC + RD_LAT_CYC);
                        state <= FCS_C_SETUP;
                    end
                end
                FCS_C_SETUP: begin
                    // address captured at the later falling edge: we (or oe) after cs
                    if (wr) begin
                        pins.write_strobe_n <= 1'b0;
                    end else begin
                        pins.output_enable_n <= 1'b0;
                    end
                    state <= FCS_C_PULSE;
                end
                FCS_C_PULSE: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        // data captured at the earlier rising edge: we rises first
                        pins.write_strobe_n  <= 1'b1;
                        pins.output_enable_n <= 1'b1;
                        if (!wr) begin
                            rdata <= data_sync;
                        end
                        state <= FCS_C_HOLD;
                    end
                end
                FCS_C_HOLD: begin
                    pins.chip_select_n <= 1'b1;
                    pins.data_oe       <= 1'b0;
                    done  <= 1'b1;
                    state <= FCS_C_IDLE;
                end
                default: state <= FCS_C_IDLE;
            endcase
        end
    end
endmodule

// ---- rtl/fcs_host.sv ----
`timescale 1ns/1ns
// Behaviour
// - single F0 write to any address is the reset command.
// - each unlocked command starts with AA then 55.
// - byte program is AA, 55, A0, then address and data.
// - erase is AA 55 80 AA 55 then 10 chip or 30 sector.
// - AA 55 90 enters autoselect until reset.
// - after timeout flag rises, only reset restores array read.
// - AA 55 20 enters bypass; then A0 plus one address/data write.
// - bypass accepts only bypass program and 90 then 00 exit.
module fcs_host (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       resetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // flash pins
    output fcs_pkg::fcs_pins_s              flash,
    output logic                            accelerate_pin,
    input  wire logic [fcs_pkg::DATA_W-1:0] flash_data_in,
    input  wire logic                       busy_flag_pin
);
    import fcs_pkg::*;

    typedef enum logic [3:0] {
        FCS_IDLE  = 4'b0001,
        FCS_ISSUE = 4'b0010,
        FCS_WAIT  = 4'b0100,
        FCS_NEXT  = 4'b1000
    } fcs_st_e;

    fcs_st_e           state;
    fcs_op_e           op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [2:0]        step;
    logic              ready;
    logic              start;
    fcs_cycle_s        req;
    logic              cyc_done;
    logic [7:0]        cyc_rdata;
    fcs_pins_s         pins;
    logic [7:0]        data_s1;
    logic [7:0]        data_s2;
    logic [1:0]        busy_sync;
    logic [7:0]        last_poll;
    logic              toggled;

    // number of bus cycles in each sequence
    function automatic logic [2:0] seq_len(input fcs_op_e o);
        case (o)
            FCS_OP_PROGRAM: seq_len = 3'd4;
            FCS_OP_CHIP_ER: seq_len = 3'd6;
            FCS_OP_SECT_ER: seq_len = 3'd6;
            FCS_OP_AUTOSEL: seq_len = 3'd3;
            FCS_OP_BYPASS:  seq_len = 3'd3;
            FCS_OP_BYP_PGM: seq_len = 3'd2;
            FCS_OP_BYP_EXT: seq_len = 3'd2;
            default:        seq_len = 3'd1;
        endcase
    endfunction

    // unlock pair value for a cycle position
    function automatic logic [7:0] unlock_byte(input logic [2:0] s);
        unlock_byte = s[0] ? CMD_UNLOCK2 : CMD_UNLOCK1;
    endfunction

    // address and data of step s of the operation
    function automatic fcs_cycle_s seq_cycle(input fcs_op_e o, input logic [2:0] s,
                                             input logic [ADDR_W-1:0] a, input logic [7:0] d);
        fcs_cycle_s c;
        c = '{write: 1'b1, addr: '0, data: CMD_RESET};
        case (o)
            FCS_OP_READ: begin
                c.write = 1'b0;   // array read needs no command
                c.addr  = a;
            end
            FCS_OP_PROGRAM: begin
                if (s < 3'd2) c.data = unlock_byte(s);
                else if (s == 3'd2) c.data = CMD_PROGRAM;
                else begin
                    c.addr = a;
                    c.data = d;
                end
            end
            FCS_OP_CHIP_ER, FCS_OP_SECT_ER: begin
                if (s == 3'd2) c.data = CMD_ERASE_SET;
                else if (s < 3'd5) c.data = unlock_byte((s < 3'd2) ? s : s - 3'd3);   // second pair repeats AA 55
                else if (o == FCS_OP_CHIP_ER) c.data = CMD_CHIP_ERASE;
                else begin
                    c.addr = {a[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
                    c.data = CMD_SECT_ERASE;
                end
            end
            FCS_OP_AUTOSEL, FCS_OP_BYPASS: begin
                if (s < 3'd2) c.data = unlock_byte(s);
                else begin
                    c.addr = {a[ADDR_W-1], {(ADDR_W-1){1'b0}}};   // top bit half select
                    c.data = (o == FCS_OP_AUTOSEL) ? CMD_AUTOSEL : CMD_BYPASS;
                end
            end
            FCS_OP_BYP_PGM: begin
                if (s == 3'd0) c.data = CMD_PROGRAM;
                else begin
                    c.addr = a;
                    c.data = d;
                end
            end
            FCS_OP_BYP_EXT: c.data = (s == 3'd0) ? CMD_AUTOSEL : CMD_BYP_EXIT;
            FCS_OP_SUSPEND: c.data = CMD_SUSPEND;
            FCS_OP_RESUME:  c.data = CMD_RESUME;
            FCS_OP_RAW:     begin
                c.addr = a;   // arbitrary write, lets software probe recovery
                c.data = d;
            end
            default: c.data = CMD_RESET;
        endcase
        return c;
    endfunction

    // two-flop synchronisers for flash outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            data_s1   <= 8'h00;
            data_s2   <= 8'h00;
            busy_sync <= 2'b11;
        end else begin
            data_s1   <= flash_data_in;
            data_s2   <= data_s1;
            busy_sync <= {busy_sync[0], busy_flag_pin};
        end
    end

    assign req = seq_cycle(op, step, addr, wdata);

    fcs_cycle u_cycle (
        .clock     (clock),
        .resetn    (resetn),
        .start     (start),
        .req       (req),
        .done      (cyc_done),
        .rdata     (cyc_rdata),
        .pins      (pins),
        .data_sync (data_s2)
    );

    // register the pins so top outputs come from flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flash <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_enable_n: 1'b1,
                       addr: '0, data_out: 8'h00, data_oe: 1'b0};
        end else begin
            flash <= pins;
        end
    end

    // sequencer: walks the cycles of the chosen command
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state     <= FCS_IDLE;
            step      <= 3'd0;
            start     <= 1'b0;
            ready     <= 1'b1;
            rdata     <= 8'h00;
            last_poll <= 8'h00;
            toggled   <= 1'b0;
        end else begin
            start <= 1'b0;
            case (state)
                FCS_IDLE: begin
                    if (psel && penable && pwrite && paddr == REG_CTRL && pwdata[CTRL_GO_LSB]) begin
                        step  <= 3'd0;
                        ready <= 1'b0;
                        state <= FCS_ISSUE;
                    end
                end
                FCS_ISSUE: begin
                    start <= 1'b1;
                    state <= FCS_WAIT;
                end
                FCS_WAIT: begin
                    if (cyc_done) begin
                        if (!req.write) begin
                            // successive reads compare toggle bit of status
                            toggled   <= (cyc_rdata[6] != last_poll[6]);
                            last_poll <= cyc_rdata;
                            rdata     <= cyc_rdata;
                        end
                        state <= FCS_NEXT;
                    end
                end
                FCS_NEXT: begin
                    if (step + 3'd1 < seq_len(op)) begin
                        step  <= step + 3'd1;
                        state <= FCS_ISSUE;
                    end else begin
                        ready <= 1'b1;
                        state <= FCS_IDLE;
                    end
                end
                default: state <= FCS_IDLE;
            endcase
        end
    end

    // software-written operands; ctrl write ignored while a sequence runs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            op             <= FCS_OP_READ;
            addr           <= '0;
            wdata          <= 8'h00;
            accelerate_pin <= 1'b0;
        end else if (psel && penable && pwrite) begin
            case (paddr)
                REG_ADDR: addr  <= pwdata[ADDR_W-1:0];
                REG_DATA: wdata <= pwdata[7:0];
                REG_CTRL: begin
                    if (state == FCS_IDLE) begin
                        op             <= fcs_op_e'(pwdata[CTRL_OP_LSB +: 4]);
                        accelerate_pin <= pwdata[CTRL_ACC];
                    end
                end
                default: ;
            endcase
        end
    end

    // apb read path and zero-wait answer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    REG_CTRL:   prdata <= {23'h0, accelerate_pin, op, 4'h0};
                    REG_ADDR:   prdata <= {{(32-ADDR_W){1'b0}}, addr};
                    REG_DATA:   prdata <= {24'h0, wdata};
                    // timeout bit means a reset command is needed
                    REG_STATUS: prdata <= {27'h0, toggled, rdata[7], rdata[5], ready, !busy_sync[1]};
                    REG_RDATA:  prdata <= {24'h0, rdata};
                    default:    pslverr <= 1'b1;
                endcase
            end else if (psel && !penable && !(paddr inside {REG_CTRL, REG_ADDR, REG_DATA})) begin
                pslverr <= 1'b1;
            end
        end
    end

    // a write strobe never overlaps output enable
    no_contention_a: assert property (@(posedge clock) disable iff (!resetn)
        !(flash.write_strobe_n == 1'b0 && flash.output_enable_n == 1'b0))
        else $error("strobe and output enable low together");

    // data driven throughout every write pulse
    data_driven_a: assert property (@(posedge clock) disable iff (!resetn)
        !flash.write_strobe_n |-> flash.data_oe && !flash.chip_select_n)
        else $error("write pulse without data drive");

    // first cycle of a program is the first unlock byte
    unlock_first_a: assert property (@(posedge clock) disable iff (!resetn)
        start && op == FCS_OP_PROGRAM && step == 3'd0 |-> req.data == CMD_UNLOCK1)
        else $error("program does not open with unlock");

    // program third cycle carries the program command
    program_cmd_a: assert property (@(posedge clock) disable iff (!resetn)
        start && op == FCS_OP_PROGRAM && step == 3'd2 |-> req.data == CMD_PROGRAM)
        else $error("program command byte wrong");

    // sector erase sixth cycle carries 30 at a sector-aligned address
    erase_last_a: assert property (@(posedge clock) disable iff (!resetn)
        start && op == FCS_OP_SECT_ER && step == 3'd5 |-> req.data == CMD_SECT_ERASE
            && req.addr[SECT_LSB-1:0] == '0)
        else $error("sector erase cycle wrong");

    // each sequence ends after its own length
    seq_length_a: assert property (@(posedge clock) disable iff (!resetn)
        state == FCS_NEXT && step + 3'd1 >= seq_len(op) |=> ready && state == FCS_IDLE)
        else $error("sequence length wrong");

    // bypass exit is 90 then 00
    bypass_exit_a: assert property (@(posedge clock) disable iff (!resetn)
        start && op == FCS_OP_BYP_EXT |-> req.data == (step == 3'd0 ? CMD_AUTOSEL : CMD_BYP_EXIT))
        else $error("bypass exit bytes wrong");

    // a started cycle completes with strobes back high
    cycle_ends_a: assert property (@(posedge clock) disable iff (!resetn)
        start |-> ##[3:12] cyc_done)
        else $error("bus cycle did not finish");
endmodule

// ---- verification/fcs_flash_model.sv ----
`timescale 1ns/1ns
// behavioural flash part answering the host pins
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5e,  // arbitrary value
    parameter logic [7:0] PART_ID  = 8'h6b,  // arbitrary value
    parameter logic [5:0] PROT_SEC = 6'h01,
    parameter int         PGM_NS   = 400,
    parameter int         ERS_NS   = 2000
) (
    // host pins
    input  wire fcs_pkg::fcs_pins_s    pins,
    input  wire logic                  accelerate_pin,
    // answers
    output logic [fcs_pkg::DATA_W-1:0] data_q,
    output logic                       busy_flag_pin = 1'b1
);
    logic [7:0]  mem [256];
    logic [21:0] a;
    logic [7:0]  rd;
    logic [7:0]  last = 8'h00;
    logic [7:0]  pd = 8'h00;
    logic        autosel = 0;
    logic        bypass = 0;
    logic        tog = 0;
    logic        susp = 0;
    logic        ers = 0;
    logic        half = 0;
    logic [5:0]  es = 6'h00;
    int          gen = 0;
    int          step = 0;
    wire         wr_n = pins.chip_select_n | pins.write_strobe_n;
    wire         rd_en = !pins.chip_select_n && !pins.output_enable_n;

    // array reads right after power-up
    initial foreach (mem[i]) mem[i] = 8'hff;

    // address at the later falling strobe
    always @(negedge wr_n) a = pins.addr;

    // internal algorithm; busy low until it ends, then back to array read
    task automatic algo(input int ns, input logic [7:0] ix, input logic [7:0] d, input logic era);
        int g;
        gen++;
        g = gen;
        busy_flag_pin = 0;
        pd = d;
        fork
            begin
                #ns;
                // a suspend retires this run
                if (g == gen) begin
                    if (era) foreach (mem[i]) mem[i] = 8'hff;
                    else mem[ix] = mem[ix] & d;
                    if (era) ers = 0;
                    busy_flag_pin = 1;
                end
            end
        join_none
    endtask

    // command decode at the earlier rising strobe
    always @(posedge wr_n) begin
        logic [7:0] d;
        d = pins.data_out;
        if (!busy_flag_pin) begin
            if (ers && !susp && d == CMD_SUSPEND) begin
                gen++;
                susp = 1;
                busy_flag_pin = 1;
            end
            step = 0;
        end else if (susp && step == 0 && d == CMD_RESUME) begin
            susp = 0;
            algo(ERS_NS, 8'h00, d, 1);
        end else if (bypass || accelerate_pin) begin
            if (step == 7) algo(PGM_NS, a[7:0], d, 0);
            if (step == 8 && d == CMD_BYP_EXIT) bypass = 0;
            step = (step == 0 && d == CMD_PROGRAM) ? 7 : (step == 0 && d == CMD_AUTOSEL) ? 8 : 0;
        end else if (d == CMD_RESET) begin
            step = 0;
            autosel = 0;
        end else case (step)
            0, 3: step = (d == CMD_UNLOCK1) ? step + 1 : 0;
            1, 4: step = (d == CMD_UNLOCK2) ? step + 1 : 0;
            2: begin
                step = (d == CMD_ERASE_SET) ? 3 : (d == CMD_PROGRAM) ? 6 : 0;
                autosel = autosel | (d == CMD_AUTOSEL);
                if (d == CMD_AUTOSEL) half = a[21];
                bypass = (d == CMD_BYPASS);
            end
            5: begin
                if (d == CMD_CHIP_ERASE || d == CMD_SECT_ERASE) begin
                    ers = (d == CMD_SECT_ERASE);
                    es = a[21:16];
                    algo(ERS_NS, 8'h00, d, 1);
                end
                step = 0;
            end
            default: begin
                algo(PGM_NS, a[7:0], d, 0);
                step = 0;
            end
        endcase
    end

    // read path: status while busy, 80 in the suspended sector, codes in autoselect, else array
    always @* begin
        if (!busy_flag_pin) rd = {~pd[7], tog, 6'h00};
        else if (susp && pins.addr[21:16] == es) rd = 8'h80;
        else if (autosel) case (pins.addr[7:0])
            AS_MAKER:   rd = MAKER_ID;
            AS_PART:    rd = PART_ID;
            AS_PROTECT: rd = {7'h00, pins.addr[21:16] == PROT_SEC && !accelerate_pin
                              && pins.addr[21] == half};
            default:    rd = 8'h00;
        endcase
        else rd = mem[pins.addr[7:0]];
    end

    // status toggles per read; a released bus shows the inverse of the last value
    always @(posedge pins.output_enable_n) tog = ~tog;
    always @* if (rd_en) last = rd;
    assign data_q = rd_en ? rd : ~last;
endmodule

// ---- verification/tb_flash_command_state_machine.sv ----
`timescale 1ns/1ns
// bench for the flash command host
module tb_flash_command_state_machine;
    import fcs_pkg::*;
    localparam logic [7:0] MAKER = 8'h5e;  // arbitrary value
    localparam logic [7:0] PART  = 8'h6b;  // arbitrary value
    logic        clock, resetn, psel, penable, pwrite, pready, pslverr, accelerate_pin, busy_flag_pin, acc, er;
    logic [7:0]  paddr, q, flash_data_in;
    logic [31:0] pwdata, prdata, r;
    fcs_pins_s   flash;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;

    // clock
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end

    fcs_host i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash(flash),
        .accelerate_pin(accelerate_pin), .flash_data_in(flash_data_in), .busy_flag_pin(busy_flag_pin));
    fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_flash (.pins(flash),
        .accelerate_pin(accelerate_pin), .data_q(flash_data_in), .busy_flag_pin(busy_flag_pin));

    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // one host operation, waited out on status, result byte returned
    task automatic run(input logic [3:0] op, input logic [21:0] a, input logic [7:0] d);
        apb(1, REG_ADDR, {10'h000, a});
        apb(1, REG_DATA, {24'h000000, d});
        apb(1, REG_CTRL, {23'h000000, acc, op, 4'h1});
        repeat (4) @(posedge clock);
        do apb(0, REG_STATUS, 0); while (r[ST_READY] !== 1'b1 || r[ST_BUSY] !== 1'b0);
        apb(0, REG_RDATA, 0);
        q = r[7:0];
    endtask

    task automatic t_program();
        run(FCS_OP_READ, 22'h12, 0);
        chk("boot read", 8'hff, q);
        run(FCS_OP_PROGRAM, 22'h12, 8'h5a);
        run(FCS_OP_READ, 22'h12, 0);
        chk("program", 8'h5a, q);
        run(FCS_OP_PROGRAM, 22'h12, 8'hff);
        run(FCS_OP_READ, 22'h12, 0);
        chk("zero kept", 8'h5a, q);
    endtask

    // broken sequence, then program aborted by reset before its data
    task automatic t_bad_seq();
        logic [7:0] ds [8] = '{8'haa, 8'h55, 8'h77, 8'haa, 8'h55, 8'ha0, 8'hf0, 8'h00};
        foreach (ds[i]) run(FCS_OP_RAW, 22'h12, ds[i]);
        run(FCS_OP_READ, 22'h12, 0);
        chk("bad sequence", 8'h5a, q);
    endtask

    task automatic t_autosel();
        logic [21:0] ad [4] = '{22'h0, 22'h1, 22'h010002, 22'h000002};
        logic [7:0]  ex [4] = '{MAKER, PART, 8'h01, 8'h00};
        run(FCS_OP_AUTOSEL, 22'h0, 0);
        for (int k = 0; k < 2; k++)
            foreach (ad[i]) begin
                run(FCS_OP_READ, ad[i], 0);
                chk("autoselect", ex[i], q);
            end
        run(FCS_OP_RESET, 22'h3f00, 0);
        run(FCS_OP_READ, 22'h12, 0);
        chk("after reset", 8'h5a, q);
    endtask

    task automatic t_bypass();
        run(FCS_OP_BYPASS, 0, 0);
        run(FCS_OP_BYP_PGM, 22'h34, 8'hc3);
        run(FCS_OP_BYP_PGM, 22'h35, 8'h0f);
        run(FCS_OP_BYP_EXT, 0, 0);
        run(FCS_OP_READ, 22'h34, 0);
        chk("bypass a", 8'hc3, q);
        run(FCS_OP_READ, 22'h35, 0);
        chk("bypass b", 8'h0f, q);
    endtask

    task automatic t_erase();
        run(FCS_OP_CHIP_ER, 0, 0);
        run(FCS_OP_READ, 22'h12, 0);
        chk("chip erase", 8'hff, q);
        run(FCS_OP_PROGRAM, 22'h40, 8'ha5);
        run(FCS_OP_SECT_ER, 22'h40, 0);
        run(FCS_OP_READ, 22'h40, 0);
        chk("sector erase", 8'hff, q);
    endtask

    task automatic t_accel();
        acc = 1;
        run(FCS_OP_BYP_PGM, 22'h50, 8'h3c);
        chk("accelerate pin", 1'b1, accelerate_pin);
        acc = 0;
        run(FCS_OP_READ, 22'h50, 0);
        chk("accelerated program", 8'h3c, q);
        chk("accelerate off", 1'b0, accelerate_pin);
    endtask

    task automatic t_apb();
        apb(0, 8'h20, 0);
        chk("unmapped error", 1'b1, er);
        apb(0, REG_STATUS, 0);
        chk("mapped error", 1'b0, er);
    endtask

    // suspend ignored when idle; sector erase suspended, read around, resumed
    task automatic t_suspend();
        run(FCS_OP_PROGRAM, 22'h12, 8'h66);
        run(FCS_OP_SUSPEND, 0, 0);
        run(FCS_OP_RESUME, 0, 0);
        run(FCS_OP_READ, 22'h12, 0);
        chk("idle suspend", 8'h66, q);
        apb(1, REG_ADDR, 32'h0001_0040);
        apb(1, REG_CTRL, {23'h000000, acc, FCS_OP_SECT_ER, 4'h1});
        do apb(0, REG_STATUS, 0); while (r[ST_READY] !== 1'b1);
        chk("erase busy", 1'b1, r[ST_BUSY]);
        run(FCS_OP_SUSPEND, 0, 0);
        run(FCS_OP_READ, 22'h010040, 0);
        chk("suspended sector", 1'b1, q[7]);
        run(FCS_OP_READ, 22'h12, 0);
        chk("other sector", 8'h66, q);
        run(FCS_OP_RESUME, 0, 0);
        run(FCS_OP_READ, 22'h12, 0);
        chk("resumed erase", 8'hff, q);
    endtask

    // main sequence
    initial begin
        {psel, penable, pwrite, acc} = 0;
        paddr = 0;
        pwdata = 0;
        resetn = 0;
        repeat (8) @(posedge clock);
        resetn <= 1;
        t_apb();
        t_program();
        t_bad_seq();
        t_autosel();
        t_bypass();
        t_accel();
        t_erase();
        t_suspend();
        results();
    end
endmodule
